//--- core/tcc_timer.sv
// 16-bit timer/counter with input capture behind an AHB-Lite slave
//
// Decided for this implementation: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ns
// Overview of operation
// - counter seen as high and low byte
// - low access moves high byte via latch
// - clock select picks tick source
// - select zero stops; access still works
// - software write beats counting
// - tick clears, increments or decrements by mode
// - overflow flag per mode, may interrupt
// - matching edge copies counter to capture
// - capture flag set with the copy
// - capture flag interrupts; cleared by service/one
// - capture low read fills latch
// - capture writable only in capture-top modes
// - comparator select replaces capture pin
// - filter changes after four agreeing samples
// - filter enable adds four cycles delay
// - filter runs on undivided clock
// - capture input off in capture-top modes
// - pin driven by port still captures
// - each capture overwrites previous value
// - latch keeps value between low writes
// - one latch shared by all wide registers
module tcc_timer (
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // asynchronous event inputs
   input  wire logic        capture_pin,
   input  wire logic        comparator_output,
   input  wire logic        external_count_pin,
   // interrupt requests (overflow or capture)
   output logic             irq,
   input  wire logic        capture_irq_ack
);
   import tcc_pkg::*;

   tcc_state_s r;
   tcc_state_s n;

   logic [3:0]  wgm;
   logic [2:0]  csel;
   logic        tick;
   logic        cap_top;
   logic [15:0] top;
   logic        src;
   logic        edge_in;
   logic        trig;
   logic        all_same;
   logic        wr;
   logic        rd;
   logic [7:0]  wb;
   logic [7:0]  ra;
   logic        ovf_set;
   logic        filt_now;

   // mode decode from both control registers
   assign wgm     = {r.ctl_b[CTLB_WGM_LSB+1:CTLB_WGM_LSB], r.ctl_a[1:0]};
   assign csel    = r.ctl_b[CTLB_CLK_LSB+2:CTLB_CLK_LSB];
   assign cap_top = (wgm == WGM_CTC_CAPTURE) || (wgm == WGM_PFC_CAPTURE) ||
                    (wgm == WGM_PC_CAPTURE) || (wgm == WGM_FAST_CAPTURE);
   assign top     = cap_top ? r.capture :
                    (wgm == WGM_CTC_COMPARE) ? r.compare : MAX_VALUE;
   // trigger source after synchronisers; port-driven pin seen like any level
   assign src      = r.cap_sel ? r.cmp_sync[1] : r.cap_sync[1];
   // filter output moves only once all four stored samples agree; the stored
   // samples cost exactly four cycles against the unfiltered edge path
   assign all_same = (r.hist == {FILTER_SAMPLES{r.hist[0]}});
   assign filt_now = all_same ? r.hist[0] : r.filt;
   assign edge_in  = r.ctl_b[CTLB_FILTER_BIT] ? filt_now : src;
   assign trig     = !cap_top && (edge_in != r.edge_prev) &&
                     (edge_in == r.ctl_b[CTLB_EDGE_BIT]);
   assign wr  = r.req.pend && r.req.write;
   // reads decode in the address phase so the data phase finds them in a flop
   assign rd  = hsel && hready && htrans[1] && !hwrite;
   assign ra  = {haddr[7:2], 2'b00};
   assign wb  = hwdata[7:0];

   // tick select: prescaler taps and synchronised external pin edges
   always_comb begin
      tick = 1'b0;
      case (csel)
         3'd0: tick = 1'b0;
         3'd1: tick = 1'b1;
         3'd2: tick = (r.presc[2:0] == 3'h7);
         3'd3: tick = (r.presc[5:0] == 6'h3F);
         3'd4: tick = (r.presc[7:0] == 8'hFF);
         3'd5: tick = (r.presc == 10'h3FF);
         3'd6: tick = r.ext_prev && !r.ext_sync[1];
         3'd7: tick = !r.ext_prev && r.ext_sync[1];
         default: tick = 1'b0;
      endcase
   end

   // next state: bus, counter, capture, flags
   always_comb begin
      n = r;
      n.cap_sync  = {r.cap_sync[0], capture_pin};
      n.cmp_sync  = {r.cmp_sync[0], comparator_output};
      n.ext_sync  = {r.ext_sync[0], external_count_pin};
      n.ext_prev  = r.ext_sync[1];
      n.presc     = r.presc + 10'h001;
      // filter sampled every hclk, prescaler plays no part
      n.hist      = {r.hist[FILTER_SAMPLES-2:0], src};
      n.filt      = filt_now;
      n.edge_prev = edge_in;

      // counting per waveform mode; the overflow set is applied after the
      // software clears so that an overflow in a clearing cycle survives
      ovf_set = 1'b0;
      if (tick) begin
         if (wgm == WGM_CTC_CAPTURE || wgm == WGM_CTC_COMPARE) begin
            n.count = (r.count == top) ? COUNT_RESET : r.count + 16'h0001;
            ovf_set = (r.count == MAX_VALUE);
         end else if (wgm == WGM_PFC_CAPTURE || wgm == WGM_PC_CAPTURE) begin
            if (r.down) begin
               n.count = r.count - 16'h0001;
               if (r.count == 16'h0001) begin
                  n.down  = 1'b0;
                  ovf_set = 1'b1;
               end
            end else begin
               n.count = r.count + 16'h0001;
               if (r.count + 16'h0001 >= top) begin
                  n.down = 1'b1;
               end
            end
         end else begin
            n.count = (r.count == top) ? COUNT_RESET : r.count + 16'h0001;
            ovf_set = (r.count == top);
         end
      end

      // capture overwrites regardless of whether software read it
      if (trig) begin
         n.capture  = r.count;
      end

      // flag clears: service ack or write one; a new event wins
      if (capture_irq_ack) begin
         n.cap_flag = 1'b0;
      end

      // ahb address phase capture
      n.req.pend = 1'b0;
      if (hsel && hready && htrans[1]) begin
         n.req.pend  = 1'b1;
         n.req.write = hwrite;
         n.req.addr  = {haddr[7:2], 2'b00};
         n.bus       = TCC_DATA;
      end else begin
         n.bus = TCC_ADDR;
      end

      // register writes; high locations only reach the latch
      if (wr) begin
         case (r.req.addr)
            OFS_COUNT_HIGH, OFS_CAPTURE_HIGH, OFS_COMPARE_HIGH: begin
               n.latch = wb;
            end
            OFS_COUNT_LOW: begin
               n.count = {r.latch, wb};
            end
            OFS_CAPTURE_LOW: begin
               if (cap_top) begin
                  n.capture = {r.latch, wb};
               end
            end
            OFS_COMPARE_LOW: n.compare = {r.latch, wb};
            OFS_CONTROL_A:   n.ctl_a   = wb;
            OFS_CONTROL_B:   n.ctl_b   = wb;
            OFS_FLAGS: begin
               if (wb[FLAG_OVF_BIT]) begin
                  n.ovf_flag = 1'b0;
               end
               if (wb[FLAG_CAP_BIT]) begin
                  n.cap_flag = 1'b0;
               end
            end
            OFS_IRQ_ENABLE: begin
               n.ovf_en = wb[FLAG_OVF_BIT];
               n.cap_en = wb[FLAG_CAP_BIT];
            end
            OFS_COMPARATOR: n.cap_sel = wb[CMPC_SEL_BIT];
            default: n.cap_sel = r.cap_sel;
         endcase
      end

      // sets placed last so an event in a clearing cycle survives
      if (trig) begin
         n.cap_flag = 1'b1;
      end
      if (ovf_set && !(wr && r.req.addr == OFS_COUNT_LOW)) begin
         n.ovf_flag = 1'b1;
      end

      // reads take the settled next values, so a write still in its data
      // phase is already seen by a read right behind it; count and capture low reads fill the latch
      n.rdata = 32'h0000_0000;
      if (rd) begin
         case (ra)
            OFS_COUNT_LOW: begin
               n.rdata[7:0] = n.count[7:0];
               n.latch      = n.count[15:8];
            end
            OFS_CAPTURE_LOW: begin
               n.rdata[7:0] = n.capture[7:0];
               n.latch      = n.capture[15:8];
            end
            OFS_COUNT_HIGH, OFS_CAPTURE_HIGH: n.rdata[7:0] = n.latch;
            OFS_COMPARE_LOW:  n.rdata[7:0] = n.compare[7:0];
            OFS_COMPARE_HIGH: n.rdata[7:0] = n.compare[15:8];
            OFS_CONTROL_A:    n.rdata[7:0] = n.ctl_a;
            OFS_CONTROL_B:    n.rdata[7:0] = n.ctl_b;
            OFS_FLAGS: begin
               n.rdata[FLAG_OVF_BIT] = n.ovf_flag;
               n.rdata[FLAG_CAP_BIT] = n.cap_flag;
            end
            OFS_IRQ_ENABLE: begin
               n.rdata[FLAG_OVF_BIT] = n.ovf_en;
               n.rdata[FLAG_CAP_BIT] = n.cap_en;
            end
            OFS_COMPARATOR: n.rdata[CMPC_SEL_BIT] = n.cap_sel;
            default: n.rdata = 32'h0000_0000;
         endcase
      end
      n.irq = (n.cap_flag && n.cap_en) || (n.ovf_flag && n.ovf_en);
   end

   // single state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r <= '0;
         r.bus <= TCC_ADDR;
      end else begin
         r <= n;
      end
   end

   // read data and irq straight from flops, ready and response tied off; zero-wait slave
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = r.rdata;
   assign irq       = r.irq;
endmodule

//--- pkg/tcc_pkg.sv
// package: register map, field layout and state type of the 16-bit timer with capture
package tcc_pkg;
   // register byte offsets (one aligned word each, data in the low bits)
   localparam logic [7:0] OFS_COUNT_LOW    = 8'h00;
   localparam logic [7:0] OFS_COUNT_HIGH   = 8'h04;
   localparam logic [7:0] OFS_CAPTURE_LOW  = 8'h08;
   localparam logic [7:0] OFS_CAPTURE_HIGH = 8'h0C;
   localparam logic [7:0] OFS_COMPARE_LOW  = 8'h10;
   localparam logic [7:0] OFS_COMPARE_HIGH = 8'h14;
   localparam logic [7:0] OFS_CONTROL_A    = 8'h18;
   localparam logic [7:0] OFS_CONTROL_B    = 8'h1C;
   localparam logic [7:0] OFS_FLAGS        = 8'h20;
   localparam logic [7:0] OFS_IRQ_ENABLE   = 8'h24;
   localparam logic [7:0] OFS_COMPARATOR   = 8'h28;
   // field positions
   localparam int CTLB_CLK_LSB     = 0; // clock_select_field [2:0]
   localparam int CTLB_WGM_LSB     = 3; // waveform mode bits 4:3
   localparam int CTLB_EDGE_BIT    = 6; // 1 = rising edge captures
   localparam int CTLB_FILTER_BIT  = 7; // capture_filter_enable
   localparam int FLAG_OVF_BIT     = 0;
   localparam int FLAG_CAP_BIT     = 5;
   localparam int CMPC_SEL_BIT     = 2; // comparator_capture_select
   // reset values and the counter maximum
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [7:0]  BYTE_RESET  = 8'h00;
   localparam logic [15:0] MAX_VALUE   = 16'hFFFF;
   // filter needs this many agreeing samples
   localparam int FILTER_SAMPLES = 4;
   // waveform modes that take top from the capture value, then the one that takes it from compare
   localparam logic [3:0] WGM_CTC_CAPTURE  = 4'hC;
   localparam logic [3:0] WGM_PFC_CAPTURE  = 4'h8;
   localparam logic [3:0] WGM_PC_CAPTURE   = 4'hA;
   localparam logic [3:0] WGM_FAST_CAPTURE = 4'hE;
   localparam logic [3:0] WGM_CTC_COMPARE  = 4'h4;

   typedef enum logic [1:0] {
      TCC_ADDR = 2'b01,
      TCC_DATA = 2'b10
   } tcc_bus_e;

   typedef struct packed {
      logic       pend;
      logic       write;
      logic [7:0] addr;
   } tcc_req_s;

   typedef struct packed {
      tcc_bus_e            bus;
      tcc_req_s            req;
      logic [31:0]         rdata;
      logic [15:0]         count;
      logic [15:0]         capture;
      logic [15:0]         compare;
      logic [7:0]          latch;
      logic [7:0]          ctl_a;
      logic [7:0]          ctl_b;
      logic                cap_sel;
      logic                ovf_flag;
      logic                cap_flag;
      logic                ovf_en;
      logic                cap_en;
      logic                irq;
      logic [1:0]          cap_sync;
      logic [1:0]          cmp_sync;
      logic [1:0]          ext_sync;
      logic                ext_prev;
      logic [FILTER_SAMPLES-1:0] hist;
      logic                filt;
      logic                edge_prev;
      logic                down;
      logic [9:0]          presc;
   } tcc_state_s;
endpackage

//--- bench/tcc_evt_src.sv
// event source model: the pins that feed capture and counting
`timescale 1ns/1ns
module tcc_evt_src (
   // clock
   input  wire logic       clk,
   // levels asked for: bit0 capture, bit1 comparator, bit2 count pin
   input  wire logic [2:0] want,
   // pin levels
   output logic            cap = 1'b0,
   output logic            cmp = 1'b0,
   output logic            ext = 1'b0
);
   // levels move just after an edge, as a port bit written by software would
   always @(posedge clk) begin
      {ext, cmp, cap} <= want;
   end
endmodule

//--- bench/tcc_timer_props.sv
// checker: bus answer and shared high byte relations of the timer
`timescale 1ns/1ns
module tcc_timer_props (
   // clock and reset
   input wire logic        hclk,
   input wire logic        hresetn,
   // bus
   input wire logic        hsel,
   input wire logic [7:0]  haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   input wire logic        irq
);
   import tcc_pkg::*;
   logic       dv, dw, pv, pw, eo;
   logic [7:0] da, pa, pd;
   wire        rhi = dv & ~dw & (da == OFS_COUNT_HIGH | da == OFS_CAPTURE_HIGH);
   wire        phi = pa == OFS_COUNT_HIGH | pa == OFS_CAPTURE_HIGH;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // data phase, last finished transfer, both enables off
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {dv, dw, da, pv, pw, pa, pd, eo} <= 29'h0000001;
      end else begin
         {dv, dw, da} <= {hsel & hready & htrans[1], hwrite, haddr};
         if (dv) begin
            {pv, pw, pa} <= {1'b1, dw, da};
            pd <= dw ? hwdata[7:0] : hrdata[7:0];
         end
         if (dv && dw && da == OFS_IRQ_ENABLE) begin
            eo <= ~(hwdata[FLAG_OVF_BIT] | hwdata[FLAG_CAP_BIT]);
         end
      end
   end
   property p_ready; hreadyout; endproperty
   property p_okay; !hresp; endproperty
   property p_upper; dv && !dw |-> hrdata[31:8] == 24'h0; endproperty
   property p_unmap; dv && !dw && da > OFS_COMPARATOR |-> hrdata == 32'h0; endproperty
   property p_lat_wr;
      rhi && pv && pw && (phi || pa == OFS_COMPARE_HIGH) |-> hrdata[7:0] == pd;
   endproperty
   property p_lat_rd; rhi && pv && !pw && phi |-> hrdata[7:0] == pd; endproperty
   property p_en_rb;
      dv && !dw && da == OFS_IRQ_ENABLE && pv && pw && pa == OFS_IRQ_ENABLE
         |-> hrdata[5] == pd[5] && hrdata[0] == pd[0];
   endproperty
   property p_irq_off; eo && $past(eo) |-> !irq; endproperty
   a_ready: assert property (p_ready) else $error("ready low");
   a_okay: assert property (p_okay) else $error("response not okay");
   a_upper: assert property (p_upper) else $error("read above byte");
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   a_lat_wr: assert property (p_lat_wr) else $error("latch lost write");
   a_lat_rd: assert property (p_lat_rd) else $error("latch changed");
   a_en_rb: assert property (p_en_rb) else $error("enable readback");
   a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
   c_irq: cover property (!eo && $rose(irq));
   c_lat: cover property (rhi && pv && pw);
   c_unmap: cover property (dv && da > OFS_COMPARATOR);
endmodule
bind tcc_timer tcc_timer_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq));

//--- bench/tb_tcc_timer.sv
// bench: stimulus and checks for the timer with capture
`timescale 1ns/1ns
module tb_tcc_timer;
   import tcc_pkg::*;
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, ack = 1'b0;
   logic [7:0]  haddr = 8'h00;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] hwdata = 32'h0, hrdata, r, v;
   logic [2:0]  want = 3'h0;
   logic [15:0] a;
   logic        hreadyout, hresp, irq, cap, cmp, ext;
   integer      seed = 32'hB3DB4301;
   int          fail_count = 0, checks_done = 0;
   // the one slave's ready is the bus ready
   tcc_timer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .capture_pin(cap),
      .comparator_output(cmp), .external_count_pin(ext), .irq(irq), .capture_irq_ack(ack));
   tcc_evt_src src (.clk(hclk), .want(want), .cap(cap), .cmp(cmp), .ext(ext));
   always #4 hclk = ~hclk;
   // single transfer; the leading idle edge keeps writes settled before reads
   task automatic xfer(input logic [7:0] ad, input logic w, input logic [7:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= ad;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
      hsel <= 1'b0;
   endtask
   task automatic rd16(input logic [7:0] lo, output logic [15:0] q);
      // low first, both halves back to back: nothing else reaches the latch
      xfer(lo, 1'b0, 8'h00);
      q[7:0] = r[7:0];
      xfer(lo + 8'h04, 1'b0, 8'h00);
      q[15:8] = r[7:0];
   endtask
   task automatic wr16(input logic [7:0] lo, input logic [15:0] d);
      xfer(lo + 8'h04, 1'b1, d[15:8]);
      xfer(lo, 1'b1, d[7:0]);
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         fail_count++;
         $display("Error %0t: saw %h expected %h", $time, g, e);
      end
   endtask
   function automatic logic [7:0] ctlb(input logic [2:0] cs, input logic rise, filt);
      ctlb = {filt, rise, 3'b000, cs};
   endfunction
   // stopped count is set, pins move, sync and edge logic settle
   task automatic ev(input logic [15:0] c, input logic [2:0] p);
      wr16(OFS_COUNT_LOW, c);
      want <= p;
      repeat (12) @(posedge hclk);
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge hclk);
      fail_count++;
      complete_run;
   end
   initial begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      // one high write serves two low writes
      repeat (4) begin
         v = $random(seed);
         xfer(OFS_COUNT_HIGH, 1'b1, v[15:8]);
         xfer(OFS_COUNT_HIGH, 1'b0, 8'h00);
         chk(r[7:0], v[15:8]);
         xfer(OFS_COUNT_LOW, 1'b1, v[7:0]);
         xfer(OFS_COMPARE_LOW, 1'b1, v[23:16]);
         rd16(OFS_COUNT_LOW, a);
         chk(a, v[15:0]);
         xfer(OFS_CAPTURE_HIGH, 1'b0, 8'h00);
         chk(r[7:0], v[15:8]);
         rd16(OFS_COMPARE_LOW, a);
         chk(a, {v[15:8], v[23:16]});
      end
      // overflow past the top raises the request; write one clears it
      xfer(OFS_IRQ_ENABLE, 1'b1, 8'h01);
      wr16(OFS_COUNT_LOW, 16'hFFF0);
      xfer(OFS_CONTROL_B, 1'b1, ctlb(3'h1, 1'b0, 1'b0));
      repeat (30) @(posedge hclk);
      chk(irq, 1'b1);
      xfer(OFS_FLAGS, 1'b1, 8'h01);
      xfer(OFS_CONTROL_B, 1'b1, ctlb(3'h7, 1'b1, 1'b0));
      chk(irq, 1'b0);
      // external rising edges, three steps
      wr16(OFS_COUNT_LOW, 16'h0100);
      repeat (3) begin
         want <= 3'b100;
         repeat (6) @(posedge hclk);
         want <= 3'b000;
         repeat (6) @(posedge hclk);
      end
      xfer(OFS_CONTROL_B, 1'b1, ctlb(3'h0, 1'b1, 1'b0));
      rd16(OFS_COUNT_LOW, a);
      chk(a, 16'h0103);
      // stamp of a stopped count, flag, request and acknowledge
      xfer(OFS_IRQ_ENABLE, 1'b1, 8'h20);
      xfer(OFS_IRQ_ENABLE, 1'b0, 8'h00);
      chk(r & 32'h21, 32'h20);
      v = $random(seed);
      ev(v[15:0], 3'b001);
      chk(irq, 1'b1);
      xfer(OFS_FLAGS, 1'b0, 8'h00);
      chk(r[5], 1'b1);
      rd16(OFS_CAPTURE_LOW, a);
      chk(a, v[15:0]);
      ack <= 1'b1;
      @(posedge hclk);
      ack <= 1'b0;
      repeat (3) @(posedge hclk);
      chk(irq, 1'b0);
      // falling selected: earlier stamp overwritten, rising ignored
      xfer(OFS_CONTROL_B, 1'b1, ctlb(3'h0, 1'b0, 1'b0));
      ev(16'hABCD, 3'b000);
      ev(16'h5555, 3'b001);
      rd16(OFS_CAPTURE_LOW, a);
      chk(a, 16'hABCD);
      xfer(OFS_FLAGS, 1'b1, 8'h20);
      xfer(OFS_FLAGS, 1'b0, 8'h00);
      chk(r[5], 1'b0);
      // comparator as source; the switch may stamp, so clear after it
      xfer(OFS_COMPARATOR, 1'b1, 8'h04);
      xfer(OFS_FLAGS, 1'b1, 8'h20);
      ev(16'h7777, 3'b011);
      ev(16'h3C3C, 3'b001);
      ev(16'h6666, 3'b000);
      rd16(OFS_CAPTURE_LOW, a);
      chk(a, 16'h3C3C);
      // filter drops a three-sample glitch, takes a steady level
      xfer(OFS_COMPARATOR, 1'b1, 8'h00);
      xfer(OFS_CONTROL_B, 1'b1, ctlb(3'h0, 1'b1, 1'b1));
      xfer(OFS_FLAGS, 1'b1, 8'h20);
      want <= 3'b001;
      repeat (3) @(posedge hclk);
      want <= 3'b000;
      repeat (12) @(posedge hclk);
      xfer(OFS_FLAGS, 1'b0, 8'h00);
      chk(r[5], 1'b0);
      ev(16'h4444, 3'b001);
      rd16(OFS_CAPTURE_LOW, a);
      chk(a, 16'h4444);
      // capture-top mode: writable, pin ignored; refused elsewhere
      xfer(OFS_CONTROL_B, 1'b1, 8'h18);
      wr16(OFS_CAPTURE_LOW, v[31:16]);
      ev(16'h9999, 3'b000);
      rd16(OFS_CAPTURE_LOW, a);
      chk(a, v[31:16]);
      xfer(OFS_CONTROL_B, 1'b1, 8'h00);
      xfer(OFS_CAPTURE_LOW, 1'b1, 8'h5A);
      rd16(OFS_CAPTURE_LOW, a);
      chk(a, v[31:16]);
      xfer(8'h2C, 1'b1, 8'hFF);
      xfer(8'h2C, 1'b0, 8'h00);
      chk(r, 32'h0);
      complete_run;
   end
endmodule
